// >>> inc/emac_pkg.sv
/*
 * Shared constants for the MAC frame buffer and filter: register offsets,
 * control and status bit positions, buffer geometry, CRC constants, states.
 * Assumes a 32-bit APB register bus and byte-wide streams to the PHY.
 */
`default_nettype none
package emac_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_RXCTL  = 12'h008;
  localparam logic [11:0] OFS_TXCTL  = 12'h00C;
  localparam logic [11:0] OFS_DATA   = 12'h010;
  localparam logic [11:0] OFS_IA0    = 12'h014;
  localparam logic [11:0] OFS_IA1    = 12'h018;
  localparam logic [11:0] OFS_NP     = 12'h034;
  localparam logic [11:0] OFS_TR     = 12'h038;
  // ==========================================================
  // Field positions and reset values
  localparam int ST_RXINT = 0;
  localparam int ST_TXERR = 1;
  localparam int ST_TXOK  = 2;
  localparam int ST_OVF   = 3;
  localparam int ST_RXERR = 4;
  localparam int ST_MGMT  = 5;
  localparam int ST_PHY   = 6;
  localparam int ST_W     = 7;
  localparam int TXC_EN   = 0;
  localparam int TXC_PAD  = 1;
  localparam int TXC_CRC  = 2;
  localparam int TXC_DUP  = 4;
  localparam int RXC_EN   = 0;
  localparam int RXC_ALL_MULTICAST_ENABLE = 1;
  localparam int RXC_PROMISCUOUS_ENABLE = 2;
  localparam int RXC_BAD  = 3;
  localparam int CTL_W    = 8;
  localparam int NP_W     = 6;
  localparam logic [7:0] RXCTL_RST = 8'h08;
  localparam logic [7:0] TXCTL_RST = 8'h00;
  // ==========================================================
  // Buffer geometry and frame layout
  localparam int          AW          = 9;
  localparam logic [9:0]  BUF_WORDS   = 10'h200;
  localparam logic [9:0]  TX_FULL     = 10'h200;
  localparam logic [5:0]  MAX_FRAMES  = 6'h1F;
  localparam logic [15:0] MIN_PAYLOAD = 16'h002E;
  localparam logic [11:0] FIRST_OCT   = 12'h002;
  localparam logic [11:0] DA_END      = 12'h008;
  localparam logic [11:0] HDR_END     = 12'h010;
  localparam logic [11:0] FCS_LEN     = 12'h004;
  localparam logic [11:0] ROUND_UP    = 12'h003;
  localparam logic [11:0] MIN_BODY    = 12'h03C;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [47:0] BCAST_ADDR  = 48'hFFFFFFFFFFFF;
  // ==========================================================
  // States
  typedef enum logic [2:0] {TX_IDLE, TX_LEN, TX_FETCH, TX_LATCH, TX_SEND, TX_PADDING, TX_FCS} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_RECV, RX_COMMIT} rx_state_type;
endpackage : emac_pkg
`default_nettype wire

// >>> rtl/crc32_byte.sv
/*
 * One byte step of the reflected Ethernet CRC-32, purely combinational.
 * Assumes the data byte is consumed least significant bit first.
 */
`default_nettype none
module crc32_byte
  import emac_pkg::*;
(
  input  wire logic [31:0] crcIn,
  input  wire logic [7:0]  dataIn,
  output logic      [31:0] crcOut
);
  // ==========================================================
  // Bit-serial stages
  logic [31:0] stage [0:8];

  assign stage[0] = crcIn;
  for (genvar g = 0; g < 8; g++) begin : g_bit
    assign stage[g+1] = (stage[g][0] ^ dataIn[g]) ? ((stage[g] >> 1) ^ CRC_POLY) : (stage[g] >> 1);
  end
  assign crcOut = stage[8];
endmodule : crc32_byte
`default_nettype wire

// >>> rtl/ethernet_mac_fifo_filter.sv
/*
 * MAC frame buffering: single-frame transmit buffer, multi-frame receive
 * buffer, FCS generation and check, padding, address filter, event flags.
 * Assumes APB from the host, byte streams to and from the PHY, and at
 * least one idle cycle between received bytes.
 */
// Function
// R1 - Transmit buffer 2 KB, one frame, 2032-byte payload
// R2 - Receive buffer 2 KB, at most 31 frames
// R3 - Frame not fitting flags overflow
// R4 - First transmit word holds payload byte count
// R5 - First receive word holds total frame length
// R6 - Octets packed little-endian, payload from word five
// R7 - Host supplies FCS word when generation off
// R8 - Next receive frame starts on fresh word
// R9 - Checksum enable appends FCS, else send unchanged
// R10 - Pad enable pads payload to 46 bytes
// R11 - Duplex bit selects full or half duplex
// R12 - Reject bit discards frames failing FCS
// R13 - Default: only broadcast and own address
// R14 - Promiscuous accepts all, all-multicast accepts group
// R15 - Flag frame stored into empty receive buffer
// R16 - Flag transmit failure and transmit success separately
// R17 - Flag frame arriving with no room
// R18 - Flag received frame with errors
// R19 - Flag each completed management transaction
// R20 - Flag any PHY event condition
// R21 - Transmit request cleared when buffer free
// R22 - Count stored frames, decrement after full read
// R23 - Data register write pushes, read pops
// R24 - Error flags latched until software acknowledges
`default_nettype none
module ethernet_mac_fifo_filter
  import emac_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  txData,
  output logic             txValid,
  input  wire logic        txReady,
  output logic             txFrame,
  input  wire logic        txCollision,
  output logic             fullDuplex,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxLast,
  input  wire logic        rxError,
  input  wire logic        mgmtDone,
  input  wire logic        phyEvent
);
  // ==========================================================
  // Declarations
  logic [CTL_W-1:0] rxCtl_r, txCtl_r;
  logic [31:0]      ia0_r, ia1_r, prdata_r, rdMux, txQ, rxQ, rxWord, wordNew;
  logic [ST_W-1:0]  status_r, stSet, stClr;
  logic             ack_r, hit, done, txReq_r, txOk, txFail;
  logic [9:0]       txWr_r;
  logic             apbRead, apbWrite, pop;
  tx_state_type     txState;
  logic [11:0]      fb_r, endB_r, txCnt_r;
  logic [15:0]      len_r;
  logic [5:0]       padLeft_r;
  logic [1:0]       txK_r;
  logic             inTail_r;
  logic [31:0]      txCrc_r, txCrcNext, fcsShift;
  logic [7:0]       txData_r;
  logic             txValid_r, txFrame_r, accept, abort;
  rx_state_type     rxState;
  logic [11:0]      bc_r, rxLen_r, lenUp;
  logic [15:0]      head_r;
  logic [31:0]      rxCrc_r, rxCrcNext;
  logic [47:0]      da_r;
  logic             ovf_r, ovfNow, rxByte, rxWe, addrOk, rxBad, keep, commit;
  logic [AW-1:0]    base_r, rdPtr_r, wIdx, rxWaddr;
  logic [9:0]       rxUsed_r, freeWords, words;
  logic [NP_W-1:0]  npr_r;
  logic [9:0]       rdLeft_r;
  logic             frameRead;
  logic [11:0]      daOfs;

  // ==========================================================
  // APB slave: one wait state on every access
  assign done     = psel && penable && ack_r;
  assign pready   = ack_r;
  assign pslverr  = ack_r && !hit;
  assign prdata   = prdata_r;
  assign apbWrite = done && pwrite && hit;
  assign apbRead  = done && !pwrite;
  assign pop      = apbRead && (paddr == OFS_DATA) && (npr_r != '0); // R23

  always_comb begin
    hit   = 1'b1;
    rdMux = '0;
    case (paddr)
      OFS_STATUS: rdMux[ST_W-1:0] = status_r;
      OFS_RXCTL:  rdMux[CTL_W-1:0] = rxCtl_r;
      OFS_TXCTL:  rdMux[CTL_W-1:0] = txCtl_r;
      OFS_DATA:   rdMux = (npr_r != '0) ? rxQ : '0;
      OFS_IA0:    rdMux = ia0_r;
      OFS_IA1:    rdMux = {16'h0000, ia1_r[15:0]};
      OFS_NP:     rdMux[NP_W-1:0] = npr_r; // R22
      OFS_TR:     rdMux[0] = txReq_r;
      default:    hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r    <= 1'b0;
      prdata_r <= '0;
    end else begin
      ack_r <= psel && penable && !ack_r;
      if (psel && penable && !ack_r) begin
        prdata_r <= rdMux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxCtl_r <= RXCTL_RST;
      txCtl_r <= TXCTL_RST;
      ia0_r   <= '0;
      ia1_r   <= '0;
    end else if (apbWrite) begin
      case (paddr)
        OFS_RXCTL: rxCtl_r <= pwdata[CTL_W-1:0];
        OFS_TXCTL: txCtl_r <= pwdata[CTL_W-1:0];
        OFS_IA0:   ia0_r   <= pwdata;
        OFS_IA1:   ia1_r   <= {16'h0000, pwdata[15:0]};
        default:   ;
      endcase
    end
  end
  assign fullDuplex = txCtl_r[TXC_DUP]; // R11

  // ==========================================================
  // Event flags, write one to clear; a set in the same cycle wins
  assign stClr = (apbWrite && paddr == OFS_STATUS) ? pwdata[ST_W-1:0] : '0;
  always_comb begin
    stSet           = '0;
    stSet[ST_RXINT] = commit && (npr_r == '0); // R15
    stSet[ST_TXERR] = txFail; // R16
    stSet[ST_TXOK]  = txOk; // R16
    stSet[ST_OVF]   = rxByte && rxLast && keep && ovfNow; // R3 R17
    stSet[ST_RXERR] = rxByte && rxLast && rxCtl_r[RXC_EN] && addrOk && rxBad; // R18
    stSet[ST_MGMT]  = mgmtDone; // R19
    stSet[ST_PHY]   = phyEvent; // R20
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~stClr) | stSet; // R24
    end
  end

  // ==========================================================
  // Transmit buffer fill and request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txWr_r  <= '0;
      txReq_r <= 1'b0;
    end else begin
      if (txOk || txFail) begin
        txWr_r  <= '0;
        txReq_r <= 1'b0; // R21
      end else if (apbWrite && paddr == OFS_DATA && !txReq_r && txWr_r != TX_FULL) begin
        txWr_r <= txWr_r + 10'd1; // R1 R23
      end
      if (apbWrite && paddr == OFS_TR && pwdata[0]) begin
        txReq_r <= 1'b1; // R21
      end
    end
  end

  frame_ram u_txRam (
    .mclk  (mclk),
    .we    (apbWrite && paddr == OFS_DATA && !txReq_r && txWr_r != TX_FULL),
    .waddr (txWr_r[AW-1:0]),
    .wdata (pwdata),
    .raddr (fb_r[AW+1:2]),
    .rdata (txQ)
  );

  // ==========================================================
  // Transmit engine: three cycles per buffered byte, one per pad or FCS byte, ample against the PHY rate
  crc32_byte u_txCrc (
    .crcIn  (txCrc_r),
    .dataIn (txData_r),
    .crcOut (txCrcNext)
  );
  assign accept   = txValid_r && txReady;
  assign abort    = txFrame_r && !txCtl_r[TXC_DUP] && txCollision; // R11
  assign fcsShift = ~txCrc_r >> {txK_r + 2'd1, 3'b000};
  assign txOk     = accept && ((txState == TX_FCS && txK_r == 2'd3) ||
                    (txState == TX_SEND && fb_r + 12'd1 == endB_r && inTail_r));
  assign txFail   = abort;
  assign txData   = txData_r;
  assign txValid  = txValid_r;
  assign txFrame  = txFrame_r;

  always_ff @(posedge mclk) begin
    if (!rst_n || abort || txOk) begin
      txState   <= TX_IDLE;
      fb_r      <= '0;
      endB_r    <= '0;
      len_r     <= '0;
      padLeft_r <= '0;
      txK_r     <= '0;
      inTail_r  <= 1'b0;
      txCrc_r   <= CRC_INIT;
      txData_r  <= '0;
      txValid_r <= 1'b0;
      txFrame_r <= 1'b0;
    end else begin
      unique case (txState)
        TX_IDLE: begin
          if (txReq_r && txCtl_r[TXC_EN]) begin
            txState <= TX_LEN;
          end
        end
        TX_LEN: begin
          len_r     <= txQ[15:0]; // R4
          endB_r    <= HDR_END + txQ[11:0]; // R6
          padLeft_r <= (txCtl_r[TXC_PAD] && txQ[15:0] < MIN_PAYLOAD) ?
                       6'(MIN_PAYLOAD - txQ[15:0]) : '0; // R10
          fb_r      <= FIRST_OCT;
          txFrame_r <= 1'b1;
          txState   <= TX_FETCH;
        end
        TX_FETCH: txState <= TX_LATCH;
        TX_LATCH: begin
          txData_r  <= txQ[{fb_r[1:0], 3'b000} +: 8]; // R6
          txValid_r <= 1'b1;
          txState   <= TX_SEND;
        end
        TX_SEND: begin
          if (accept) begin
            txCrc_r   <= txCrcNext;
            fb_r      <= fb_r + 12'd1;
            txValid_r <= 1'b0;
            txState   <= TX_FETCH;
            if (fb_r + 12'd1 == endB_r) begin
              inTail_r <= 1'b1;
              if (padLeft_r != '0) begin
                txData_r  <= '0;
                txValid_r <= 1'b1;
                txState   <= TX_PADDING; // R10
              end else if (txCtl_r[TXC_CRC]) begin
                txData_r  <= ~txCrcNext[7:0];
                txValid_r <= 1'b1;
                txState   <= TX_FCS; // R9
              end else begin
                endB_r <= endB_r + FCS_LEN; // R7 R9
              end
            end
          end
        end
        TX_PADDING: begin
          if (accept) begin
            txCrc_r   <= txCrcNext;
            padLeft_r <= padLeft_r - 6'd1;
            if (padLeft_r == 6'd1) begin
              if (txCtl_r[TXC_CRC]) begin
                txData_r <= ~txCrcNext[7:0];
                txState  <= TX_FCS; // R9
              end else begin
                txValid_r <= 1'b0;
                endB_r    <= endB_r + FCS_LEN;
                txState   <= TX_FETCH; // R7
              end
            end
          end
        end
        TX_FCS: begin
          if (accept) begin
            txK_r    <= txK_r + 2'd1;
            txData_r <= fcsShift[7:0]; // R9
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || txState == TX_LEN) begin
      txCnt_r <= '0;
    end else if (accept && (txState == TX_SEND || txState == TX_PADDING)) begin
      txCnt_r <= txCnt_r + 12'd1;
    end
  end

  // ==========================================================
  // Receive engine: pack bytes, filter, commit whole frames only
  crc32_byte u_rxCrc (
    .crcIn  (rxCrc_r),
    .dataIn (rxData),
    .crcOut (rxCrcNext)
  );
  assign rxByte    = rxValid && (rxState != RX_COMMIT);
  assign wIdx      = bc_r[AW+1:2];
  assign freeWords = BUF_WORDS - rxUsed_r;
  assign ovfNow    = ovf_r || bc_r[11] || ({1'b0, wIdx} >= freeWords); // R3
  assign daOfs     = bc_r - FIRST_OCT;
  assign addrOk    = rxCtl_r[RXC_PROMISCUOUS_ENABLE] || da_r == BCAST_ADDR ||
                     (rxCtl_r[RXC_ALL_MULTICAST_ENABLE] && da_r[0]) || da_r == {ia1_r[15:0], ia0_r}; // R13 R14
  assign rxBad     = (rxCrcNext != CRC_RESIDUE) || rxError;
  assign keep      = rxCtl_r[RXC_EN] && addrOk && !(rxCtl_r[RXC_BAD] && rxBad); // R12
  assign commit    = rxState == RX_COMMIT;
  assign lenUp     = rxLen_r + ROUND_UP;
  assign words     = lenUp[11:2];

  always_comb begin
    wordNew                            = rxWord;
    wordNew[{bc_r[1:0], 3'b000} +: 8] = rxData; // R6
  end
  assign rxWe    = commit || (rxByte && wIdx != '0 && (bc_r[1:0] == 2'd3 || rxLast) && !ovfNow);
  assign rxWaddr = commit ? base_r : base_r + wIdx;

  frame_ram u_rxRam (
    .mclk  (mclk),
    .we    (rxWe),
    .waddr (rxWaddr),
    .wdata (commit ? {head_r, 4'h0, rxLen_r} : wordNew), // R5
    .raddr (rdPtr_r),
    .rdata (rxQ)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      bc_r    <= FIRST_OCT;
      rxLen_r <= '0;
      head_r  <= '0;
      rxWord  <= '0;
      rxCrc_r <= CRC_INIT;
      da_r    <= '0;
      ovf_r   <= 1'b0;
      base_r  <= '0;
    end else if (commit) begin
      base_r  <= base_r + words[AW-1:0]; // R8
      rxState <= RX_IDLE;
    end else if (rxByte) begin
      rxWord  <= wordNew;
      rxCrc_r <= rxCrcNext;
      bc_r    <= bc_r + 12'd1;
      rxState <= RX_RECV;
      if (rxState == RX_IDLE) begin
        ovf_r <= npr_r == MAX_FRAMES; // R2
      end
      if (bc_r < DA_END) begin
        da_r[{daOfs[2:0], 3'b000} +: 8] <= rxData;
      end
      if (wIdx == '0 && bc_r[1:0] == 2'd3) begin
        head_r <= wordNew[31:16];
      end
      if (ovfNow) begin
        ovf_r <= 1'b1;
      end
      if (rxLast) begin
        rxLen_r <= bc_r + 12'd1; // R5
        bc_r    <= FIRST_OCT;
        rxCrc_r <= CRC_INIT;
        ovf_r   <= 1'b0;
        rxState <= (keep && !ovfNow) ? RX_COMMIT : RX_IDLE;
      end
    end
  end

  // ==========================================================
  // Host read side and frame accounting
  assign frameRead = pop && rdLeft_r == 10'd1;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdPtr_r  <= '0;
      rdLeft_r <= '0;
    end else if (pop) begin
      rdPtr_r <= rdPtr_r + 9'd1; // R23
      if (rdLeft_r == '0) begin
        rdLeft_r <= 10'((rxQ[11:0] + ROUND_UP) >> 2) - 10'd1;
      end else begin
        rdLeft_r <= rdLeft_r - 10'd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      npr_r    <= '0;
      rxUsed_r <= '0;
    end else begin
      npr_r    <= npr_r + NP_W'(commit) - NP_W'(frameRead); // R22
      rxUsed_r <= rxUsed_r + (commit ? words : 10'd0) - 10'(pop);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered in one wait state");
  tx_req_clear_a: assert property ((txOk || txFail) |=> !txReq_r) // R21
    else $error("transmit request not cleared after frame");
  tx_ok_flag_a: assert property (txOk |=> status_r[ST_TXOK]) // R16
    else $error("transmit success flag missing");
  tx_pad_len_a: assert property ((txState != TX_FCS ##1 txState == TX_FCS && txCtl_r[TXC_PAD]) |-> txCnt_r >= MIN_BODY) // R10
    else $error("padded frame shorter than minimum");
  tx_fcs_gen_a: assert property (txState == TX_FCS |-> txCtl_r[TXC_CRC]) // R9
    else $error("FCS generated while disabled");
  rx_ovf_flag_a: assert property (rxByte && rxLast && keep && ovfNow |=> status_r[ST_OVF] && rxState == RX_IDLE) // R17
    else $error("overflow not flagged or frame stored");
  rx_count_inc_a: assert property (commit && !frameRead |=> npr_r == $past(npr_r) + 6'd1) // R22
    else $error("frame count not incremented on store");
  rx_count_max_a: assert property (npr_r <= MAX_FRAMES) // R2
    else $error("more frames held than allowed");
  rx_empty_int_a: assert property (commit && npr_r == '0 |=> status_r[ST_RXINT]) // R15
    else $error("receive flag missing for empty buffer");
  rx_reject_a: assert property (rxByte && rxLast && rxCtl_r[RXC_BAD] && rxBad |=> !commit) // R12
    else $error("bad frame stored despite reject");
endmodule : ethernet_mac_fifo_filter
`default_nettype wire

// >>> rtl/frame_ram.sv
/*
 * 512 x 32 frame buffer with one write port and one registered read port.
 * Assumes a single clock; read data lag the read address by one edge.
 */
`default_nettype none
module frame_ram
  import emac_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  // ==========================================================
  // Storage
  logic [31:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // No reset on the read register: contents are undefined until written
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end
endmodule : frame_ram
`default_nettype wire

// >>> verif/ethernet_mac_fifo_filter_bench.sv
/*
 * Bench for the MAC frame buffer: register rows, then reset, transmit,
 * receive, filter, event and overflow cases.
 * Assumes phy_model at the far side and APB driven from here.
 */
`default_nettype none
module ethernet_mac_fifo_filter_bench import emac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic err;} row_type;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  txData, rxData;
  logic        txValid, txReady, txFrame, txCollision, fullDuplex;
  logic        rxValid, rxLast, rxError, mgmtDone, phyEvent;
  logic [31:0] frm[5];
  row_type     rows[8];
  int          miscompares, checks_done;

  ethernet_mac_fifo_filter ethernet_mac_fifo_filter_inst (.mclk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .txData, .txValid, .txReady, .txFrame, .txCollision, .fullDuplex,
    .rxValid, .rxData, .rxLast, .rxError, .mgmtDone, .phyEvent);
  phy_model phy_model_inst (.mclk, .txData, .txValid, .txReady, .stall, .rxValid, .rxData, .rxLast, .rxError);

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'h1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // No assumed wait count: only the watchdog ends a hung access
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] x);
    apb(a, 1'h0, 32'h0);
    check(nm, q, x);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask : wr
  task automatic pop(input int n);
    repeat (n) apb(OFS_DATA, 1'h0, 32'h0);
  endtask : pop
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // Whole run is well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, txCollision, mgmtDone, phyEvent, stall} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    checks_done = 0;
    frm = '{32'hFFFF0003, 32'hFFFFFFFF, 32'h44332211, 32'h00086655, 32'h00CCBBAA};
    rows = '{'{OFS_IA0, 1'h1, 32'h12345678, 32'h0, 1'h0}, '{OFS_IA0, 1'h0, 32'h0, 32'h12345678, 1'h0},
             '{OFS_RXCTL, 1'h1, 32'h0F, 32'h0, 1'h0}, '{OFS_RXCTL, 1'h0, 32'h0, 32'h0F, 1'h0},
             '{OFS_TXCTL, 1'h1, 32'h17, 32'h0, 1'h0}, '{OFS_TXCTL, 1'h0, 32'h0, 32'h17, 1'h0},
             '{12'h004, 1'h0, 32'h0, 32'h0, 1'h1}, '{12'h0FC, 1'h1, 32'h5, 32'h0, 1'h1}};
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      check("pslverr", 32'(e), 32'(rows[i].err));
      if (!rows[i].w) check("readback", q, rows[i].x);
    end
    check("duplex", 32'(fullDuplex), 32'h1);
    // Second reset in mid-run
    rst_n <= 1'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    check("duplex", 32'(fullDuplex), 32'h0);
    rd(OFS_RXCTL, "rxctl", {24'h0, RXCTL_RST});
    rd(OFS_NP, "np", 32'h0);
    // Short odd payload, padded, FCS generated, slow PHY
    wr(OFS_RXCTL, 32'h09);
    wr(OFS_TXCTL, 32'h07);
    foreach (frm[i]) wr(OFS_DATA, frm[i]);
    stall <= 1'h1;
    wr(OFS_TR, 32'h1);
    q = 32'h1;
    for (int n = 0; n < 400 && q[0] !== 1'h0; n++) apb(OFS_TR, 1'h0, 32'h0);
    check("tr", q, 32'h0);
    check("bytes", 32'(phy_model_inst.seen.size()), 32'h40);
    check("type", 32'(phy_model_inst.seen[12]), 32'h08);
    check("pay", 32'(phy_model_inst.seen[14]), 32'hAA);
    check("pad", 32'(phy_model_inst.seen[17]), 32'h00);
    rd(OFS_STATUS, "status", 32'h04);
    wr(OFS_STATUS, 32'h7F);
    stall <= 1'h0;
    // Loop the frame back: a bad FCS would be dropped here
    phy_model_inst.replay(0, 8'h00);
    rd(OFS_NP, "np", 32'h1);
    rd(OFS_STATUS, "status", 32'h01);
    rd(OFS_DATA, "word0", 32'hFFFF0042);
    pop(3);
    rd(OFS_DATA, "payload", 32'h00CCBBAA);
    pop(12);
    rd(OFS_NP, "np", 32'h0);
    wr(OFS_STATUS, 32'h7F);
    phy_model_inst.replay(20, 8'h01);
    rd(OFS_STATUS, "status", 32'h10);
    wr(OFS_STATUS, 32'h7F);
    phy_model_inst.replay(0, 8'h01);
    rd(OFS_STATUS, "status", 32'h00);
    wr(OFS_RXCTL, 32'h05);
    phy_model_inst.replay(0, 8'h01);
    rd(OFS_NP, "np", 32'h1);
    rd(OFS_DATA, "word0", 32'hFFFE0042);
    pop(16);
    rd(OFS_STATUS, "status", 32'h11);
    @(posedge mclk);
    mgmtDone <= 1'h1;
    phyEvent <= 1'h1;
    @(posedge mclk);
    mgmtDone <= 1'h0;
    phyEvent <= 1'h0;
    rd(OFS_STATUS, "status", 32'h71);
    wr(OFS_STATUS, 32'h7F);
    rd(OFS_STATUS, "status", 32'h00);
    // 17 words a frame: the 31st no longer fits
    wr(OFS_RXCTL, 32'h09);
    repeat (31) phy_model_inst.replay(0, 8'h00);
    rd(OFS_NP, "np", 32'h1E);
    rd(OFS_STATUS, "status", 32'h09);
    // FCS generation off: host FCS bytes follow the payload unchanged
    wr(OFS_STATUS, 32'h7F);
    wr(OFS_TXCTL, 32'h01);
    frm[4] = 32'hF1CCBBAA;
    foreach (frm[i]) wr(OFS_DATA, frm[i]);
    wr(OFS_DATA, 32'h00F4F3F2);
    wr(OFS_TR, 32'h1);
    repeat (150) @(posedge mclk);
    check("bytes", 32'(phy_model_inst.seen.size()), 32'h55);
    check("fcs", 32'(phy_model_inst.seen[84]), 32'hF4);
    rd(OFS_STATUS, "status", 32'h04);
    // Collision in half duplex ends the frame with the failure flag
    wr(OFS_STATUS, 32'h7F);
    foreach (frm[i]) wr(OFS_DATA, frm[i]);
    wr(OFS_TR, 32'h1);
    repeat (4) @(posedge mclk);
    check("txframe", 32'(txFrame), 32'h1);
    txCollision <= 1'h1;
    @(posedge mclk);
    txCollision <= 1'h0;
    @(posedge mclk);
    check("txframe", 32'(txFrame), 32'h0);
    rd(OFS_TR, "tr", 32'h0);
    rd(OFS_STATUS, "status", 32'h02);
    test_done();
  end
endmodule : ethernet_mac_fifo_filter_bench
`default_nettype wire

// >>> verif/phy_model.sv
/*
 * PHY stand-in: takes transmit bytes, slowly when stalled, keeps them,
 * and plays them back as a received frame with one byte optionally changed.
 * Assumes the MAC holds txValid and txData until txReady.
 */
`default_nettype none
module phy_model (
  input  wire logic       mclk,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic       stall,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxLast,
  output logic            rxError
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seen[$];
  logic [1:0] slow;
  initial begin
    txReady = 1'h0;
    rxValid = 1'h0;
    rxData  = 8'h00;
    rxLast  = 1'h0;
    rxError = 1'h0;
    slow    = 2'h0;
  end
  // ==========================================================
  // Transmit side: one ready in four while stalled
  always @(posedge mclk) begin
    slow    <= slow + 2'h1;
    txReady <= !stall || slow == 2'h3;
    if (txValid && txReady) seen.push_back(txData);
  end
  // ==========================================================
  // Receive side: bytes two cycles apart, line not left at last value
  task automatic replay(input int at, input logic [7:0] flip);
    foreach (seen[i]) begin
      @(posedge mclk);
      rxValid <= 1'h1;
      rxData  <= seen[i] ^ (i == at ? flip : 8'h00);
      rxLast  <= i == seen.size() - 1;
      @(posedge mclk);
      rxValid <= 1'h0;
      rxLast  <= 1'h0;
      rxData  <= ~rxData;
    end
    repeat (4) @(posedge mclk);
  endtask : replay
endmodule : phy_model
`default_nettype wire
